// ==== include/rf_pll_ctrl_pkg.sv ====
// rf_pll_ctrl_pkg: register offsets, field positions, reset values and
// widths shared by the rf synthesiser control block.
// assumes the serial bus decoder hands over one decoded write per word.
package rf_pll_ctrl_pkg;

  // --------------------------------------------------------------
  // register offsets on the serial control bus
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_GLOBAL_CLEAR = 8'h30;
  localparam logic [7:0] ADDR_LOOP_CONTROL = 8'h34;
  localparam logic [7:0] ADDR_LEAK_CONFIG = 8'h35;
  localparam logic [7:0] ADDR_LOCK_CONFIG = 8'h36;
  localparam logic [7:0] ADDR_SETTLE_CONFIG = 8'h37;
  localparam logic [7:0] ADDR_REF_DIVIDE = 8'h38;
  localparam logic [7:0] ADDR_FB_INTEGER = 8'h39;
  localparam logic [7:0] ADDR_FB_FRAC_LOW = 8'h3a;
  localparam logic [7:0] ADDR_FB_FRAC_HIGH = 8'h3b;

  // --------------------------------------------------------------
  // values after reset and after the global clear command
  // --------------------------------------------------------------
  localparam logic [15:0] RST_LOOP_CONTROL = 16'h0000;
  localparam logic [7:0] RST_LEAK_CONFIG = 8'h00;
  localparam logic [15:0] RST_LOCK_CONFIG = 16'h0000;
  localparam logic [15:0] RST_SETTLE_CONFIG = 16'h0000;
  localparam logic [7:0] RST_REF_DIVIDE = 8'h00;
  localparam logic [15:0] RST_FB_INTEGER = 16'h0080;
  localparam logic [15:0] RST_FB_FRAC_LOW = 16'h0000;
  localparam logic [7:0] RST_FB_FRAC_HIGH = 8'h00;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int LOOP_CP_LSB = 0;      // 4-bit pump current code
  localparam int LOOP_RES16_BIT = 9;   // 1: 16-bit fraction
  localparam int LOOP_MODE_LSB = 11;   // 4-bit mode, 0 = integer
  localparam int LEAK_SET_LSB = 0;     // 5-bit leak setting
  localparam int LEAK_EN_BIT = 5;
  localparam int LOCK_THR_LSB = 0;     // 5-bit lock threshold
  localparam int LOSS_THR_LSB = 5;     // 3-bit loss threshold
  localparam int WINDOW_LSB = 8;       // 3-bit window code
  localparam int RESET_LOCK_BIT = 13;
  localparam int DETECT_EN_BIT = 15;
  localparam int SETTLE_MULT_LSB = 0;  // 2-bit current multiplier
  localparam int SETTLE_FINE_LSB = 2;  // 7-bit fine divide
  localparam int SETTLE_COARSE_LSB = 9; // 3-bit coarse divide
  localparam int SETTLE_EN_BIT = 12;
  localparam int REF_RATIO_LSB = 0;    // 7-bit reference ratio
  localparam int FB_INT_LSB = 0;       // 11-bit integer divider

  // --------------------------------------------------------------
  // widths and counts
  // --------------------------------------------------------------
  localparam int PUMP_UNITS_W = 9;     // 25 uA units, up to 256
  localparam int LEAK_UNITS_W = 6;     // 3.125 uA units, up to 32
  localparam int SETTLE_CNT_W = 22;    // up to 4^7 * 128 cycles
  localparam int FRAC_W = 24;
  localparam int FB_INT_W = 11;

endpackage : rf_pll_ctrl_pkg

// ==== rtl/rf_pll_lock_and_divider_control.sv ====
// rf_pll_lock_and_divider_control: write-only configuration registers,
// lock detector counters, fast settle timer and reference divider of the
// fractional-N rf synthesiser.
// assumes a same-clock serial bus decoder delivering one-cycle writes,
// and an analogue window comparator whose results arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none

module rf_pll_lock_and_divider_control
  import rf_pll_ctrl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // decoded register writes from the serial bus
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regData,
  // analogue phase window comparator, asynchronous
  input wire logic phaseCompareDone,
  input wire logic phaseInWindow,
  // lock detector
  output logic detectorEnable,
  output logic [2:0] lockWindowCode,
  output logic rfLock,
  // charge pump and leak current
  output logic [rf_pll_ctrl_pkg::PUMP_UNITS_W-1:0] pumpCurrentUnits,
  output logic leakEnable,
  output logic [rf_pll_ctrl_pkg::LEAK_UNITS_W-1:0] leakCurrentUnits,
  // fast settle pin, three-signal form
  output logic fastSettlePinOut,
  output logic fastSettlePinOeN,
  output logic fastSettleActive,
  // divider controls
  output logic refTick,
  output logic [rf_pll_ctrl_pkg::FB_INT_W-1:0] feedbackInteger,
  output logic [rf_pll_ctrl_pkg::FRAC_W-1:0] feedbackFraction,
  output logic fractionalMode
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] loopControl;
    logic [7:0] leakConfig;
    logic [15:0] lockConfig;
    logic [15:0] settleConfig;
    logic [7:0] refDivide;
    logic [15:0] fbInteger;
    logic [15:0] fbFracLow;
    logic [7:0] fbFracHigh;
    logic cmpSyncA;
    logic cmpSyncB;
    logic cmpSeen;
    logic winSyncA;
    logic winSyncB;
    logic locked;
    logic [5:0] inRun;
    logic [3:0] outRun;
    logic settling;
    logic [SETTLE_CNT_W-1:0] settleLeft;
    logic [6:0] refCount;
    logic refPulse;
    logic [PUMP_UNITS_W-1:0] pumpUnits;
    logic leakOn;
    logic [LEAK_UNITS_W-1:0] leakUnits;
    logic detOn;
    logic [2:0] windowCode;
    logic [FB_INT_W-1:0] divInt;
    logic [FRAC_W-1:0] divFrac;
    logic fracMode;
    logic pinOut;
    logic pinOeN;
  } ctrl_state_t;

  ctrl_state_t cur;
  ctrl_state_t next_cur;

  // ------------------------------------------------------------------
  // decoded fields
  // ------------------------------------------------------------------
  logic wrClear;
  logic wrLoop;
  logic wrLeak;
  logic wrLock;
  logic wrSettle;
  logic wrRef;
  logic wrInt;
  logic wrFracLo;
  logic wrFracHi;
  logic compareEvent;
  logic [5:0] lockTarget;
  logic [3:0] lossTarget;
  logic [7:0] fineDivide;
  logic [2:0] coarseDivide;
  logic [SETTLE_CNT_W-1:0] settleLoad;
  logic [4:0] pumpBase;
  logic [4:0] pumpMult;
  logic [9:0] pumpProduct;
  logic [6:0] refLast;

  assign wrClear = regWrite && (regAddr == ADDR_GLOBAL_CLEAR);
  assign wrLoop = regWrite && (regAddr == ADDR_LOOP_CONTROL);
  assign wrLeak = regWrite && (regAddr == ADDR_LEAK_CONFIG);
  assign wrLock = regWrite && (regAddr == ADDR_LOCK_CONFIG);
  assign wrSettle = regWrite && (regAddr == ADDR_SETTLE_CONFIG);
  assign wrRef = regWrite && (regAddr == ADDR_REF_DIVIDE);
  assign wrInt = regWrite && (regAddr == ADDR_FB_INTEGER);
  assign wrFracLo = regWrite && (regAddr == ADDR_FB_FRAC_LOW);
  assign wrFracHi = regWrite && (regAddr == ADDR_FB_FRAC_HIGH);

  // rising edge of the synchronised compare strobe, read from stage two only
  assign compareEvent = cur.cmpSyncB && !cur.cmpSeen;

  // zero codes stand for the top of each range, except the coarse divide code
  assign lockTarget = {(cur.lockConfig[LOCK_THR_LSB +: 5] == 5'h00),
                       cur.lockConfig[LOCK_THR_LSB +: 5]};
  assign lossTarget = {(cur.lockConfig[LOSS_THR_LSB +: 3] == 3'h0),
                       cur.lockConfig[LOSS_THR_LSB +: 3]};
  assign fineDivide = {(cur.settleConfig[SETTLE_FINE_LSB +: 7] == 7'h00),
                       cur.settleConfig[SETTLE_FINE_LSB +: 7]};
  assign coarseDivide = cur.settleConfig[SETTLE_COARSE_LSB +: 3];
  // 4^coarse is a shift by twice the coarse code
  assign settleLoad = SETTLE_CNT_W'({14'h0000, fineDivide} << {coarseDivide, 1'b0});

  // pump current in 25 uA units
  assign pumpBase = {1'b0, cur.loopControl[LOOP_CP_LSB +: 4]} + 5'h01;
  assign pumpMult = cur.settling ?
                    {1'b0, cur.settleConfig[SETTLE_MULT_LSB +: 2], 2'b00} + 5'h04 :
                    5'h01;
  assign pumpProduct = pumpBase * pumpMult;

  // wraps to 127 for code zero, giving a ratio of 128
  assign refLast = cur.refDivide[REF_RATIO_LSB +: 7] - 7'h01;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_cur = cur;

    // register writes
    if (wrLoop) begin
      next_cur.loopControl = regData;
    end
    if (wrLeak) begin
      next_cur.leakConfig = regData[7:0];
    end
    if (wrLock) begin
      // the reset-lock bit is never stored, so lockConfig always holds it at zero
      next_cur.lockConfig = regData;
      next_cur.lockConfig[RESET_LOCK_BIT] = 1'b0;
    end
    if (wrSettle) begin
      next_cur.settleConfig = regData;
    end
    if (wrRef) begin
      next_cur.refDivide = regData[7:0];
    end
    if (wrInt) begin
      next_cur.fbInteger = regData;
    end
    if (wrFracLo) begin
      next_cur.fbFracLow = regData;
    end
    if (wrFracHi) begin
      next_cur.fbFracHigh = regData[7:0];
    end

    // ----------------------------------------------------------------
    // comparator synchronisers
    // ----------------------------------------------------------------
    next_cur.cmpSyncA = phaseCompareDone;
    next_cur.cmpSyncB = cur.cmpSyncA;
    next_cur.cmpSeen = cur.cmpSyncB;
    next_cur.winSyncA = phaseInWindow;
    next_cur.winSyncB = cur.winSyncA;

    // ----------------------------------------------------------------
    // lock detector
    // ----------------------------------------------------------------
    if (!cur.lockConfig[DETECT_EN_BIT]) begin
      // powered down: no lock, runs held clear
      next_cur.locked = 1'b0;
      next_cur.inRun = 6'h00;
      next_cur.outRun = 4'h0;
    end else if (compareEvent) begin
      if (!cur.locked) begin
        next_cur.outRun = 4'h0;
        if (cur.winSyncB) begin
          if (cur.inRun + 6'h01 == lockTarget) begin
            next_cur.locked = 1'b1;
            next_cur.inRun = 6'h00;
          end else begin
            next_cur.inRun = cur.inRun + 6'h01;
          end
        end else begin
          next_cur.inRun = 6'h00;
        end
      end else begin
        next_cur.inRun = 6'h00;
        if (!cur.winSyncB) begin
          if (cur.outRun + 4'h1 == lossTarget) begin
            next_cur.locked = 1'b0;
            next_cur.outRun = 4'h0;
          end else begin
            next_cur.outRun = cur.outRun + 4'h1;
          end
        end else begin
          next_cur.outRun = 4'h0;
        end
      end
    end
    // reset-lock pulse wins over a lock decided in the same cycle
    if (wrLock && regData[RESET_LOCK_BIT]) begin
      next_cur.locked = 1'b0;
      next_cur.inRun = 6'h00;
      next_cur.outRun = 4'h0;
    end

    // ----------------------------------------------------------------
    // fast settle timer, runs on the master clock
    // ----------------------------------------------------------------
    if (cur.settling) begin
      if (cur.settleLeft == SETTLE_CNT_W'(1)) begin
        next_cur.settling = 1'b0;
        next_cur.settleLeft = '0;
      end else begin
        next_cur.settleLeft = cur.settleLeft - SETTLE_CNT_W'(1);
      end
    end
    // a new integer divider write restarts the full period while SETTLE_EN_BIT is set
    if (wrInt && cur.settleConfig[SETTLE_EN_BIT]) begin
      next_cur.settling = 1'b1;
      next_cur.settleLeft = settleLoad;
    end

    // ----------------------------------------------------------------
    // reference divider
    // ----------------------------------------------------------------
    if (cur.refCount >= refLast) begin
      next_cur.refCount = 7'h00;
      next_cur.refPulse = 1'b1;
    end else begin
      next_cur.refCount = cur.refCount + 7'h01;
      next_cur.refPulse = 1'b0;
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    next_cur.pumpUnits = PUMP_UNITS_W'(pumpProduct);
    next_cur.leakOn = cur.leakConfig[LEAK_EN_BIT];
    next_cur.leakUnits = {1'b0, cur.leakConfig[LEAK_SET_LSB +: 5]} + 6'h01;
    next_cur.detOn = cur.lockConfig[DETECT_EN_BIT];
    next_cur.windowCode = cur.lockConfig[WINDOW_LSB +: 3];
    next_cur.divInt = cur.fbInteger[FB_INT_LSB +: FB_INT_W];
    next_cur.fracMode = (cur.loopControl[LOOP_MODE_LSB +: 4] != 4'h0);
    if (cur.loopControl[LOOP_MODE_LSB +: 4] == 4'h0) begin
      // integer mode ignores both fraction registers
      next_cur.divFrac = '0;
    end else if (cur.loopControl[LOOP_RES16_BIT]) begin
      // placed in the top bits so the output is always scaled by 2^-24
      next_cur.divFrac = {cur.fbFracLow, 8'h00};
    end else begin
      next_cur.divFrac = {cur.fbFracHigh, cur.fbFracLow};
    end
    next_cur.pinOut = 1'b0;
    next_cur.pinOeN = !cur.settling;

    // ----------------------------------------------------------------
    // global clear: registers back to reset, device into its idle state
    // ----------------------------------------------------------------
    if (wrClear) begin
      next_cur.loopControl = RST_LOOP_CONTROL;
      next_cur.leakConfig = RST_LEAK_CONFIG;
      next_cur.lockConfig = RST_LOCK_CONFIG;
      next_cur.settleConfig = RST_SETTLE_CONFIG;
      next_cur.refDivide = RST_REF_DIVIDE;
      next_cur.fbInteger = RST_FB_INTEGER;
      next_cur.fbFracLow = RST_FB_FRAC_LOW;
      next_cur.fbFracHigh = RST_FB_FRAC_HIGH;
      next_cur.locked = 1'b0;
      next_cur.inRun = 6'h00;
      next_cur.outRun = 4'h0;
      next_cur.settling = 1'b0;
      next_cur.settleLeft = '0;
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      cur <= '0;
      cur.loopControl <= RST_LOOP_CONTROL;
      cur.leakConfig <= RST_LEAK_CONFIG;
      cur.lockConfig <= RST_LOCK_CONFIG;
      cur.settleConfig <= RST_SETTLE_CONFIG;
      cur.refDivide <= RST_REF_DIVIDE;
      cur.fbInteger <= RST_FB_INTEGER;
      cur.fbFracLow <= RST_FB_FRAC_LOW;
      cur.fbFracHigh <= RST_FB_FRAC_HIGH;
      cur.pumpUnits <= PUMP_UNITS_W'(1);
      cur.leakUnits <= LEAK_UNITS_W'(1);
      cur.pinOeN <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign detectorEnable = cur.detOn;
  assign lockWindowCode = cur.windowCode;
  assign rfLock = cur.locked;
  assign pumpCurrentUnits = cur.pumpUnits;
  assign leakEnable = cur.leakOn;
  assign leakCurrentUnits = cur.leakUnits;
  assign fastSettlePinOut = cur.pinOut;
  assign fastSettlePinOeN = cur.pinOeN;
  assign fastSettleActive = cur.settling;
  assign refTick = cur.refPulse;
  assign feedbackInteger = cur.divInt;
  assign feedbackFraction = cur.divFrac;
  assign fractionalMode = cur.fracMode;

endmodule : rf_pll_lock_and_divider_control

`default_nettype wire

// ==== verif/rf_pll_ctrl_props.sv ====
// checker for rf_pll_lock_and_divider_control port behaviour
// assumes a bind onto the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rf_pll_ctrl_props
  import rf_pll_ctrl_pkg::*;
(
  // clock, reset and decoded writes
  input wire logic mclk,
  input wire logic srst,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regData,
  // outputs watched
  input wire logic detectorEnable,
  input wire logic rfLock,
  input wire logic leakEnable,
  input wire logic [rf_pll_ctrl_pkg::LEAK_UNITS_W-1:0] leakCurrentUnits,
  input wire logic fastSettlePinOut,
  input wire logic fastSettlePinOeN,
  input wire logic fastSettleActive,
  input wire logic [rf_pll_ctrl_pkg::FB_INT_W-1:0] feedbackInteger
);
  logic setEn;
  logic abt;
  logic [2:0] crs;
  logic [6:0] fin;
  logic [21:0] expLen;
  logic [21:0] runLen;
  wire logic clr = regWrite && regAddr == ADDR_GLOBAL_CLEAR;
  wire logic wrInt = regWrite && regAddr == ADDR_FB_INTEGER;
  // ----------------------------------------
  // shadow of the settle setup
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || clr) begin
      setEn <= 1'b0;
      crs <= 3'h0;
      fin <= 7'h0;
    end else if (regWrite && regAddr == ADDR_SETTLE_CONFIG) begin
      setEn <= regData[SETTLE_EN_BIT];
      crs <= regData[SETTLE_COARSE_LSB +: 3];
      fin <= regData[SETTLE_FINE_LSB +: 7];
    end
  end
  // a clear aborts a run, so its length is not judged
  always_ff @(posedge mclk) begin
    if (srst || clr) begin
      abt <= 1'b1;
    end else if (wrInt && setEn) begin
      abt <= 1'b0;
    end
    if (wrInt && setEn) begin
      runLen <= 22'h0;
      expLen <= 22'(fin == 7'h0 ? 8'h80 : {1'b0, fin}) << {crs, 1'b0};
    end else if (fastSettleActive) begin
      runLen <= runLen + 22'h1;
    end else begin
      runLen <= 22'h0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence int_wr_s;
    wrInt ##1 !regWrite;
  endsequence
  sequence leak_wr_s;
    regWrite && regAddr == ADDR_LEAK_CONFIG ##1 !regWrite;
  endsequence
  int_apply_a: assert property (
    int_wr_s |=> feedbackInteger == $past(regData[FB_INT_W-1:0], 2))
    else $error("integer divider not applied");
  leak_apply_a: assert property (
    leak_wr_s |=> leakEnable == $past(regData[LEAK_EN_BIT], 2)
      && leakCurrentUnits == 6'($past(regData[4:0], 2)) + 6'h1)
    else $error("leak setting not applied");
  settle_start_a: assert property (
    wrInt && setEn |=> fastSettleActive)
    else $error("settle did not start");
  pin_drive_a: assert property (
    $rose(fastSettleActive) |=> !fastSettlePinOeN)
    else $error("settle pin not driven");
  pin_release_a: assert property (
    $fell(fastSettleActive) |=> fastSettlePinOeN)
    else $error("settle pin not released");
  pin_low_a: assert property (
    fastSettlePinOut == 1'b0)
    else $error("settle pin drives high");
  settle_len_a: assert property (
    $fell(fastSettleActive) && !abt |-> runLen == expLen)
    else $error("settle length wrong");
  lock_off_a: assert property (
    !detectorEnable [*2] |-> !rfLock)
    else $error("lock while detector off");
  reset_lock_a: assert property (
    regWrite && regAddr == ADDR_LOCK_CONFIG && regData[RESET_LOCK_BIT] |=> !rfLock)
    else $error("reset lock ignored");
endmodule : rf_pll_ctrl_props
`default_nettype wire

// ==== verif/serial_host_model.sv ====
// host model: turns bench requests into decoded register writes
// assumes requests change on the falling edge of mclk
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
  import rf_pll_ctrl_pkg::*;
(
  // clock
  input wire logic mclk,
  // requests from the bench
  input wire logic reqValid,
  input wire logic [7:0] reqAddr,
  input wire logic [15:0] reqData,
  // decoded writes
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [15:0] regData
);
  logic [7:0] lastAddr = 8'h00;
  logic [15:0] lastData = 16'h0000;
  function automatic logic [15:0] used_bits(input logic [7:0] a);
    case (a)
      ADDR_LOOP_CONTROL: used_bits = 16'h7e3f;
      ADDR_LEAK_CONFIG: used_bits = 16'h003f;
      ADDR_LOCK_CONFIG: used_bits = 16'ha7ff;
      ADDR_SETTLE_CONFIG: used_bits = 16'h1fff;
      ADDR_REF_DIVIDE: used_bits = 16'h007f;
      ADDR_FB_INTEGER: used_bits = 16'h07ff;
      ADDR_FB_FRAC_HIGH: used_bits = 16'h00ff;
      default: used_bits = 16'hffff;
    endcase
  endfunction : used_bits
  // idle bus shows the inverse of the last word, never a stale copy
  assign regWrite = reqValid;
  assign regAddr = reqValid ? reqAddr : ~lastAddr;
  assign regData = reqValid ? (reqData & used_bits(reqAddr)) : ~lastData;
  always_ff @(posedge mclk) begin
    if (reqValid) begin
      lastAddr <= regAddr;
      lastData <= regData;
    end
  end
endmodule : serial_host_model
`default_nettype wire

// ==== verif/tb.sv ====
// bench for rf_pll_lock_and_divider_control: writes, lock runs, settle timing
// assumes the package, host model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rf_pll_ctrl_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic reqValid = 1'b0;
  logic [7:0] reqAddr = 8'h00;
  logic [15:0] reqData = 16'h0000;
  logic phaseCompareDone = 1'b0;
  logic phaseInWindow = 1'b0;
  logic regWrite, detectorEnable, rfLock, leakEnable, refTick, fractionalMode;
  logic fastSettlePinOut, fastSettlePinOeN, fastSettleActive;
  logic [7:0] regAddr;
  logic [15:0] regData;
  logic [2:0] lockWindowCode;
  logic [PUMP_UNITS_W-1:0] pumpCurrentUnits;
  logic [LEAK_UNITS_W-1:0] leakCurrentUnits;
  logic [FB_INT_W-1:0] feedbackInteger;
  logic [FRAC_W-1:0] feedbackFraction;
  logic [3:0] modes [5] = '{4'h0, 4'h1, 4'h2, 4'hc, 4'hd};
  int failures = 0;
  int nChecks = 0;
  int n;
  always #5 mclk = ~mclk;
  serial_host_model host (.mclk, .reqValid, .reqAddr, .reqData, .regWrite, .regAddr,
    .regData);
  rf_pll_lock_and_divider_control dut (.mclk, .srst, .regWrite, .regAddr, .regData,
    .phaseCompareDone, .phaseInWindow, .detectorEnable, .lockWindowCode, .rfLock,
    .pumpCurrentUnits, .leakEnable, .leakCurrentUnits, .fastSettlePinOut,
    .fastSettlePinOeN, .fastSettleActive, .refTick, .feedbackInteger,
    .feedbackFraction, .fractionalMode);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int w = 2);
    reqValid = 1'b1;
    reqAddr = a;
    reqData = d;
    @(negedge mclk);
    reqValid = 1'b0;
    repeat (w) @(negedge mclk);
  endtask : wr
  // window held steady around the strobe, spacing well above four cycles
  task automatic cmp(input logic inWin);
    phaseInWindow = inWin;
    repeat (2) @(negedge mclk);
    phaseCompareDone = 1'b1;
    repeat (3) @(negedge mclk);
    phaseCompareDone = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : cmp
  task automatic gap(input logic [6:0] code, input int exp);
    wr(ADDR_REF_DIVIDE, {9'h0, code});
    n = 0;
    while (refTick !== 1'b1 && n < 300) begin
      n++;
      @(negedge mclk);
    end
    n = 1;
    @(negedge mclk);
    while (refTick !== 1'b1 && n < 300) begin
      n++;
      @(negedge mclk);
    end
    chk(24'(n), 24'(exp), "tick gap");
  endtask : gap
  task automatic settle(input logic [2:0] c, input logic [6:0] f, input logic [1:0] m,
      input int len);
    wr(ADDR_SETTLE_CONFIG, {3'h0, 1'b1, c, f, m});
    wr(ADDR_FB_INTEGER, 16'h0100, 0);
    // wr returns one falling edge after the write is taken, settle already stands
    n = 0;
    while (fastSettleActive === 1'b1 && n < 70000) begin
      n++;
      if (n == 2) begin
        chk(24'(pumpCurrentUnits), 24'(12 * (m + 1)), "boost");
        chk(24'(fastSettlePinOeN), 24'h0, "pin low");
      end
      @(negedge mclk);
    end
    chk(24'(n), 24'(len), "length");
    @(negedge mclk);
    chk(24'({fastSettlePinOeN, pumpCurrentUnits}), 24'h203, "back");
  endtask : settle
  task automatic wrap_up();
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    repeat (2) @(negedge mclk);
    chk(24'(feedbackInteger), 24'(RST_FB_INTEGER[10:0]), "int rst");
    chk(24'({pumpCurrentUnits, leakCurrentUnits}), 24'h41, "pump rst");
    chk(24'({fastSettlePinOeN, rfLock, detectorEnable, leakEnable}), 24'h8, "flags");
    $display("test reset done");
    for (int c = 0; c < 16; c += 5) begin
      wr(ADDR_LOOP_CONTROL, 16'(c));
      chk(24'(pumpCurrentUnits), 24'(c + 1), "pump");
    end
    for (int s = 0; s < 32; s += 31) begin
      wr(ADDR_LEAK_CONFIG, 16'({s[0], s[4:0]}));
      chk(24'(leakEnable), 24'(s[0]), "leak en");
      chk(24'(leakCurrentUnits), 24'(s + 1), "leak");
    end
    $display("test currents done");
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_LOOP_CONTROL, {1'b0, modes[i], 11'h002});
      chk(24'(fractionalMode), 24'(modes[i] != 4'h0), "mode");
    end
    wr(ADDR_FB_FRAC_HIGH, 16'h0080);
    wr(ADDR_FB_FRAC_LOW, 16'h1234);
    chk(feedbackFraction, 24'h801234, "frac24");
    wr(ADDR_LOOP_CONTROL, 16'h6a02);
    chk(feedbackFraction, 24'h123400, "frac16");
    wr(ADDR_FB_FRAC_LOW, 16'hfedc);
    chk(feedbackFraction, 24'hfedc00, "frac16 neg");
    wr(ADDR_LOOP_CONTROL, 16'h0002);
    chk(feedbackFraction, 24'h0, "int frac");
    chk(24'(fractionalMode), 24'h0, "int mode");
    wr(ADDR_FB_INTEGER, 16'h0020);
    chk(24'(feedbackInteger), 24'h20, "int min");
    wr(ADDR_FB_INTEGER, 16'h07ff);
    wr(8'h31, 16'h0055);
    wr(8'h3c, 16'h0055);
    chk(24'(feedbackInteger), 24'h7ff, "int max");
    $display("test dividers done");
    gap(7'h01, 1);
    gap(7'h03, 3);
    gap(7'h00, 128);
    gap(7'h7f, 127);
    $display("test reference done");
    for (int w = 0; w < 8; w++) begin
      wr(ADDR_LOCK_CONFIG, 16'(w << 8));
      chk(24'(lockWindowCode), 24'(w), "window");
    end
    wr(ADDR_LOCK_CONFIG, 16'h8543);
    chk(24'(detectorEnable), 24'h1, "det on");
    cmp(1); cmp(1); cmp(0); cmp(1); cmp(1);
    chk(24'(rfLock), 24'h0, "run broken");
    cmp(1);
    chk(24'(rfLock), 24'h1, "locked");
    cmp(0); cmp(1); cmp(0);
    chk(24'(rfLock), 24'h1, "loss broken");
    cmp(0);
    chk(24'(rfLock), 24'h0, "lost");
    wr(ADDR_LOCK_CONFIG, 16'h8541);
    cmp(1);
    wr(ADDR_LOCK_CONFIG, 16'ha541);
    chk(24'(rfLock), 24'h0, "reset lock");
    cmp(1);
    chk(24'(rfLock), 24'h1, "relock");
    wr(ADDR_LOCK_CONFIG, 16'h0541);
    cmp(1);
    chk(24'({detectorEnable, rfLock}), 24'h0, "det off");
    wr(ADDR_LOCK_CONFIG, 16'h8000);
    repeat (31) cmp(1);
    chk(24'(rfLock), 24'h0, "31 in");
    cmp(1);
    chk(24'(rfLock), 24'h1, "32 in");
    repeat (7) cmp(0);
    chk(24'(rfLock), 24'h1, "7 out");
    cmp(0);
    chk(24'(rfLock), 24'h0, "8 out");
    $display("test lock done");
    settle(3'h0, 7'h02, 2'h0, 2);
    settle(3'h0, 7'h00, 2'h3, 128);
    settle(3'h1, 7'h03, 2'h1, 12);
    settle(3'h2, 7'h01, 2'h2, 16);
    wr(ADDR_SETTLE_CONFIG, 16'h0000);
    wr(ADDR_FB_INTEGER, 16'h0100);
    chk(24'(fastSettleActive), 24'h0, "disabled");
    $display("test settle done");
    wr(ADDR_GLOBAL_CLEAR, 16'h0000);
    chk(24'({feedbackInteger, pumpCurrentUnits}), {11'h080, 9'h001}, "clear");
    $display("test clear done");
    wrap_up();
  end
  initial begin
    #200000;
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : tb
bind rf_pll_lock_and_divider_control rf_pll_ctrl_props props (.mclk, .srst, .regWrite,
  .regAddr, .regData, .detectorEnable, .rfLock, .leakEnable, .leakCurrentUnits,
  .fastSettlePinOut, .fastSettlePinOeN, .fastSettleActive, .feedbackInteger);
`default_nettype wire
